/* File: tcu_consts.svh */
`ifndef TCU_CONSTS_SVH
`define TCU_CONSTS_SVH

// ****************************************************************
// register byte addresses
// ****************************************************************
`define TCU_ADDR_MODE       32'hFFFB_0000
`define TCU_ADDR_TRIGGER    32'hFFFB_0004
`define TCU_ADDR_TOUCH_CFG  32'hFFFB_000C
`define TCU_ADDR_XPOS       32'hFFFB_0050
`define TCU_ADDR_PRESS_ONE  32'hFFFB_0054
`define TCU_ADDR_PRESS_TWO  32'hFFFB_0058
`define TCU_ADDR_SWITCH     32'hFFFB_0060
`define TCU_ADDR_GUARD_MODE 32'hFFFB_00E4
`define TCU_ADDR_GUARD_STAT 32'hFFFB_00E8
`define TCU_ADDR_IRQ_STAT   32'hFFFB_00F0
`define TCU_ADDR_IRQ_EN     32'hFFFB_00F4
`define TCU_ADDR_IRQ_CLR    32'hFFFB_00F8

// ****************************************************************
// fields and reset values
// ****************************************************************
`define TCU_RES_W           10
`define TCU_CHAN_N          3
`define TCU_SW_W            4
`define TCU_GUARD_KEY       24'h54_5341
`define TCU_GUARD_KEY_LSB   8
`define TCU_GUARD_EN_BIT    0
`define TCU_PRESS_EN_BIT    0
`define TCU_ST_DONE_LSB     0
`define TCU_ST_OVR_LSB      3
`define TCU_ST_VIOL_BIT     6
`define TCU_ST_W            7
`define TCU_OFS_KEEP_W      16
`define TCU_REG_RESET       32'h0000_0000
`define TCU_RESP_OKAY       2'h0
`define TCU_RESP_SLVERR     2'h2

`endif

/* File: tcu_panel_model.sv */
`timescale 1ns/10ps
`default_nettype none
`include "tcu_consts.svh"

module tcu_panel_model (
    // clock
    input  wire logic                  clk_i,
    // stimulus
    input  wire logic [2:0]            go_i,
    input  wire logic [`TCU_RES_W-1:0] level_i,
    // results
    output var tcu_pkg::tcu_result_t [2:0] res_o
);
    // data toggles between pulses so a stale code never looks held
    initial res_o = '0;
    always @(posedge clk_i) begin
        for (int i = 0; i < 3; i++) begin
            res_o[i].valid <= go_i[i];
            res_o[i].data <= go_i[i] ? level_i : ~res_o[i].data;
        end
    end
endmodule
`default_nettype wire

/* File: tcu_pkg.sv */
`include "tcu_consts.svh"

package tcu_pkg;

    // one conversion result offered by the sequencer
    typedef struct packed {
        logic                  valid;
        logic [`TCU_RES_W-1:0] data;
    } tcu_result_t;

    // per channel sticky flags
    typedef struct packed {
        logic overrun;
        logic done;
    } tcu_chan_flags_t;

endpackage

/* File: tcu_result_chan.sv */
`timescale 1ns/10ps
`default_nettype none
`include "tcu_consts.svh"

module tcu_result_chan (
    // clock and reset
    input  wire logic                    clk_i,
    input  wire logic                    rst_n_i,
    // converter side
    input  wire tcu_pkg::tcu_result_t    result_i,
    input  wire logic                    press_en_i,
    // register side
    input  wire logic                    read_i,
    input  wire logic                    clr_done_i,
    input  wire logic                    clr_ovr_i,
    output logic [`TCU_RES_W-1:0]        data_o,
    output tcu_pkg::tcu_chan_flags_t     flags_o
);

    logic unread;

    // ****************************************************************
    // result hold, done and overrun
    // ****************************************************************
    // a read in the same cycle as a new result consumes the old one
    wire next_unread  = result_i.valid | (unread & ~read_i);
    wire ovr_event    = result_i.valid & unread & ~read_i;
    // done is forced low while pressure measurement is off
    wire next_done    = press_en_i &
                        (result_i.valid | (flags_o.done & ~clr_done_i));
    // set wins over clear
    wire next_overrun = ovr_event | (flags_o.overrun & ~clr_ovr_i);

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            data_o  <= '0;
            unread  <= 1'b0;
            flags_o <= '0;
        end else begin
            if (result_i.valid) begin
                data_o <= result_i.data;
            end
            unread          <= next_unread;
            flags_o.done    <= next_done;
            flags_o.overrun <= next_overrun;
        end
    end

endmodule

`default_nettype wire

/* File: tcu_touch_unit.sv */
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "tcu_consts.svh"

// Contract
// - x position result read-only, 10 low bits
// - pressure one result read-only, 10 low bits
// - pressure two result read-only, 10 low bits
// - bits 0-3 close x+/x-/y+/y- switches
// - enable bit one with key enables guard
// - enable bit zero with key disables guard
// - guarded: mode, trigger, touch config writes refused
// - guard status bit 0 shows guard state
// - refused write offset low 16 bits captured in status 23:8, bits 31:24 read zero
// - x done set only with pressure enabled
// - x overrun when new result precedes read
module tcu_touch_unit (
    // clock and reset
    input  wire logic                 SYS_CLK_I,
    input  wire logic                 RST_N_I,
    // axi4-lite write address
    input  wire logic [31:0]          S_AXI_AWADDR_I,
    input  wire logic                 S_AXI_AWVALID_I,
    output logic                      S_AXI_AWREADY_O,
    // axi4-lite write data
    input  wire logic [31:0]          S_AXI_WDATA_I,
    input  wire logic [3:0]           S_AXI_WSTRB_I,
    input  wire logic                 S_AXI_WVALID_I,
    output logic                      S_AXI_WREADY_O,
    // axi4-lite write response
    output logic [1:0]                S_AXI_BRESP_O,
    output logic                      S_AXI_BVALID_O,
    input  wire logic                 S_AXI_BREADY_I,
    // axi4-lite read address
    input  wire logic [31:0]          S_AXI_ARADDR_I,
    input  wire logic                 S_AXI_ARVALID_I,
    output logic                      S_AXI_ARREADY_O,
    // axi4-lite read data
    output logic [31:0]               S_AXI_RDATA_O,
    output logic [1:0]                S_AXI_RRESP_O,
    output logic                      S_AXI_RVALID_O,
    input  wire logic                 S_AXI_RREADY_I,
    // conversion sequencer
    input  wire tcu_pkg::tcu_result_t [`TCU_CHAN_N-1:0] CONV_RESULT_I,
    input  wire logic [`TCU_SW_W-1:0] SWITCH_CMD_I,
    output logic [31:0]               MODE_O,
    output logic [31:0]               TRIGGER_O,
    output logic [31:0]               TOUCH_CFG_O,
    // panel switches
    output logic                      X_PLUS_SWITCH_O,
    output logic                      X_MINUS_SWITCH_O,
    output logic                      Y_PLUS_SWITCH_O,
    output logic                      Y_MINUS_SWITCH_O,
    // interrupt
    output logic                      IRQ_O
);

    // ****************************************************************
    // declarations
    // ****************************************************************
    logic                          aw_full;
    logic                          w_full;
    logic [31:0]                   aw_addr;
    logic [31:0]                   w_data;
    logic [3:0]                    w_strb;
    logic                          awready;
    logic                          wready;
    logic                          bvalid;
    logic [1:0]                    bresp;
    logic                          arready;
    logic                          rvalid;
    logic [1:0]                    rresp;
    logic [31:0]                   rdata;

    logic [31:0]                   mode_reg;
    logic [31:0]                   trigger_reg;
    logic [31:0]                   touch_cfg;
    logic                          guard_on;
    logic [23:0]                   offset_err;
    logic                          viol_flag;
    logic [`TCU_ST_W-1:0]          irq_en;
    logic [`TCU_SW_W-1:0]          switch_cmd;
    logic                          irq;

    logic [`TCU_CHAN_N-1:0][`TCU_RES_W-1:0] chan_data;
    tcu_pkg::tcu_chan_flags_t [`TCU_CHAN_N-1:0] chan_flags;
    logic [`TCU_CHAN_N-1:0]        chan_done;
    logic [`TCU_CHAN_N-1:0]        chan_ovr;
    logic [`TCU_CHAN_N-1:0]        rd_pulse;

    // ****************************************************************
    // byte strobe merge
    // ****************************************************************
    function automatic logic [31:0] merge_bytes(
        input logic [31:0] old_val,
        input logic [31:0] new_val,
        input logic [3:0]  strb
    );
        logic [31:0] res;
        res = old_val;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[8*b +: 8] = new_val[8*b +: 8];
            end
        end
        return res;
    endfunction

    // ****************************************************************
    // write decode
    // ****************************************************************
    // one write at a time: both halves held and no response pending
    wire wr_go          = aw_full & w_full & ~bvalid;
    wire hit_mode       = aw_addr == `TCU_ADDR_MODE;
    wire hit_trigger    = aw_addr == `TCU_ADDR_TRIGGER;
    wire hit_touch_cfg  = aw_addr == `TCU_ADDR_TOUCH_CFG;
    wire hit_guard_mode = aw_addr == `TCU_ADDR_GUARD_MODE;
    wire hit_irq_en     = aw_addr == `TCU_ADDR_IRQ_EN;
    wire hit_irq_clr    = aw_addr == `TCU_ADDR_IRQ_CLR;
    wire hit_ro         = (aw_addr == `TCU_ADDR_XPOS)      |
                          (aw_addr == `TCU_ADDR_PRESS_ONE) |
                          (aw_addr == `TCU_ADDR_PRESS_TWO) |
                          (aw_addr == `TCU_ADDR_SWITCH)    |
                          (aw_addr == `TCU_ADDR_GUARD_STAT)|
                          (aw_addr == `TCU_ADDR_IRQ_STAT);
    wire hit_guarded    = hit_mode | hit_trigger | hit_touch_cfg;
    wire wr_mapped      = hit_guarded | hit_guard_mode | hit_irq_en |
                          hit_irq_clr | hit_ro;

    // key must match in full; partial writes cannot carry it
    wire key_ok         = (w_data[31:`TCU_GUARD_KEY_LSB] ==
                           `TCU_GUARD_KEY) & (&w_strb);
    wire guard_wr       = wr_go & hit_guard_mode & key_ok;
    wire guarded_ok     = wr_go & hit_guarded & ~guard_on;
    wire refused        = wr_go & hit_guarded & guard_on;
    wire mode_wr        = guarded_ok & hit_mode;
    wire trigger_wr     = guarded_ok & hit_trigger;
    wire touch_cfg_wr   = guarded_ok & hit_touch_cfg;
    wire irq_en_wr      = wr_go & hit_irq_en;
    wire [`TCU_ST_W-1:0] clr_vec =
        (wr_go & hit_irq_clr) ? w_data[`TCU_ST_W-1:0] : '0;
    wire [23:0] refused_ofs = {{(24-`TCU_OFS_KEEP_W){1'b0}},
                               aw_addr[`TCU_OFS_KEEP_W-1:0]};
    wire [1:0] next_bresp = wr_mapped ? `TCU_RESP_OKAY
                                      : `TCU_RESP_SLVERR;

    // ****************************************************************
    // read decode
    // ****************************************************************
    wire rd_go          = S_AXI_ARVALID_I & arready;
    wire rd_xpos        = S_AXI_ARADDR_I == `TCU_ADDR_XPOS;
    wire rd_press_one   = S_AXI_ARADDR_I == `TCU_ADDR_PRESS_ONE;
    wire rd_press_two   = S_AXI_ARADDR_I == `TCU_ADDR_PRESS_TWO;
    wire rd_switch      = S_AXI_ARADDR_I == `TCU_ADDR_SWITCH;
    wire rd_mode        = S_AXI_ARADDR_I == `TCU_ADDR_MODE;
    wire rd_trigger     = S_AXI_ARADDR_I == `TCU_ADDR_TRIGGER;
    wire rd_touch_cfg   = S_AXI_ARADDR_I == `TCU_ADDR_TOUCH_CFG;
    wire rd_guard_mode  = S_AXI_ARADDR_I == `TCU_ADDR_GUARD_MODE;
    wire rd_guard_stat  = S_AXI_ARADDR_I == `TCU_ADDR_GUARD_STAT;
    wire rd_irq_stat    = S_AXI_ARADDR_I == `TCU_ADDR_IRQ_STAT;
    wire rd_irq_en      = S_AXI_ARADDR_I == `TCU_ADDR_IRQ_EN;
    wire rd_irq_clr     = S_AXI_ARADDR_I == `TCU_ADDR_IRQ_CLR;

    assign chan_done = {chan_flags[2].done, chan_flags[1].done,
                        chan_flags[0].done};
    assign chan_ovr  = {chan_flags[2].overrun, chan_flags[1].overrun,
                        chan_flags[0].overrun};
    wire [`TCU_ST_W-1:0] irq_status = {viol_flag, chan_ovr, chan_done};

    wire [31:0] rd_res_x   = {22'h00_0000, chan_data[0]};
    wire [31:0] rd_res_one = {22'h00_0000, chan_data[1]};
    wire [31:0] rd_res_two = {22'h00_0000, chan_data[2]};
    wire [31:0] rd_sw      = {28'h000_0000, switch_cmd};
    wire [31:0] rd_gmode   = {31'h0000_0000, guard_on};
    wire [31:0] rd_gstat   = {offset_err, 7'h00, guard_on};
    wire [31:0] rd_istat   = {25'h000_0000, irq_status};
    wire [31:0] rd_ien     = {25'h000_0000, irq_en};

    wire rd_mapped = rd_xpos | rd_press_one | rd_press_two | rd_switch |
                     rd_mode | rd_trigger | rd_touch_cfg | rd_guard_mode |
                     rd_guard_stat | rd_irq_stat | rd_irq_en | rd_irq_clr;

    // clear register is write-only and reads zero
    wire [31:0] next_rdata =
        rd_xpos       ? rd_res_x    :
        rd_press_one  ? rd_res_one  :
        rd_press_two  ? rd_res_two  :
        rd_switch     ? rd_sw       :
        rd_mode       ? mode_reg    :
        rd_trigger    ? trigger_reg :
        rd_touch_cfg  ? touch_cfg   :
        rd_guard_mode ? rd_gmode    :
        rd_guard_stat ? rd_gstat    :
        rd_irq_stat   ? rd_istat    :
        rd_irq_en     ? rd_ien      : 32'h0000_0000;
    wire [1:0] next_rresp = rd_mapped ? `TCU_RESP_OKAY
                                      : `TCU_RESP_SLVERR;

    // reading a result marks it consumed for overrun tracking
    assign rd_pulse = {rd_go & rd_press_two, rd_go & rd_press_one,
                       rd_go & rd_xpos};

    // ****************************************************************
    // axi4-lite write channel
    // ****************************************************************
    always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            aw_full <= 1'b0;
            w_full  <= 1'b0;
            aw_addr <= 32'h0000_0000;
            w_data  <= 32'h0000_0000;
            w_strb  <= 4'h0;
            awready <= 1'b0;
            wready  <= 1'b0;
            bvalid  <= 1'b0;
            bresp   <= `TCU_RESP_OKAY;
        end else begin
            if (S_AXI_AWVALID_I & awready) begin
                aw_full <= 1'b1;
                aw_addr <= S_AXI_AWADDR_I;
                awready <= 1'b0;
            end else if (!aw_full && !bvalid) begin
                awready <= 1'b1;
            end
            if (S_AXI_WVALID_I & wready) begin
                w_full <= 1'b1;
                w_data <= S_AXI_WDATA_I;
                w_strb <= S_AXI_WSTRB_I;
                wready <= 1'b0;
            end else if (!w_full && !bvalid) begin
                wready <= 1'b1;
            end
            if (wr_go) begin
                aw_full <= 1'b0;
                w_full  <= 1'b0;
                bvalid  <= 1'b1;
                bresp   <= next_bresp;
            end else if (bvalid & S_AXI_BREADY_I) begin
                bvalid  <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // axi4-lite read channel
    // ****************************************************************
    always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            arready <= 1'b0;
            rvalid  <= 1'b0;
            rresp   <= `TCU_RESP_OKAY;
            rdata   <= 32'h0000_0000;
        end else if (rd_go) begin
            arready <= 1'b0;
            rvalid  <= 1'b1;
            rresp   <= next_rresp;
            rdata   <= next_rdata;
        end else if (rvalid & S_AXI_RREADY_I) begin
            rvalid  <= 1'b0;
            arready <= 1'b1;
        end else if (!rvalid) begin
            arready <= 1'b1;
        end
    end

    // ****************************************************************
    // guarded configuration registers
    // ****************************************************************
    always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            mode_reg    <= `TCU_REG_RESET;
            trigger_reg <= `TCU_REG_RESET;
            touch_cfg   <= `TCU_REG_RESET;
        end else begin
            if (mode_wr) begin
                mode_reg <= merge_bytes(mode_reg, w_data, w_strb);
            end
            if (trigger_wr) begin
                trigger_reg <= merge_bytes(trigger_reg, w_data, w_strb);
            end
            if (touch_cfg_wr) begin
                touch_cfg <= merge_bytes(touch_cfg, w_data, w_strb);
            end
        end
    end

    // ****************************************************************
    // write guard
    // ****************************************************************
    // set wins over clear for the violation flag
    wire next_viol = refused |
                     (viol_flag & ~clr_vec[`TCU_ST_VIOL_BIT]);

    always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            guard_on   <= 1'b0;
            offset_err <= 24'h00_0000;
            viol_flag  <= 1'b0;
        end else begin
            if (guard_wr) begin
                guard_on <= w_data[`TCU_GUARD_EN_BIT];
            end
            if (refused) begin
                offset_err <= refused_ofs;
            end
            viol_flag <= next_viol;
        end
    end

    // ****************************************************************
    // result channels
    // ****************************************************************
    wire press_en = touch_cfg[`TCU_PRESS_EN_BIT];

    for (genvar c = 0; c < `TCU_CHAN_N; c++) begin : g_chan
        tcu_result_chan u_chan (
            .clk_i      (SYS_CLK_I),
            .rst_n_i    (RST_N_I),
            .result_i   (CONV_RESULT_I[c]),
            .press_en_i (press_en),
            .read_i     (rd_pulse[c]),
            .clr_done_i (clr_vec[`TCU_ST_DONE_LSB + c]),
            .clr_ovr_i  (clr_vec[`TCU_ST_OVR_LSB + c]),
            .data_o     (chan_data[c]),
            .flags_o    (chan_flags[c])
        );
    end

    // ****************************************************************
    // switches and interrupt
    // ****************************************************************
    always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            switch_cmd <= '0;
            irq_en     <= '0;
            irq        <= 1'b0;
        end else begin
            switch_cmd <= SWITCH_CMD_I;
            if (irq_en_wr) begin
                irq_en <= w_data[`TCU_ST_W-1:0];
            end
            // one cycle behind the flags, keeps the output a flop
            irq <= |(irq_status & irq_en);
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign S_AXI_AWREADY_O  = awready;
    assign S_AXI_WREADY_O   = wready;
    assign S_AXI_BVALID_O   = bvalid;
    assign S_AXI_BRESP_O    = bresp;
    assign S_AXI_ARREADY_O  = arready;
    assign S_AXI_RVALID_O   = rvalid;
    assign S_AXI_RRESP_O    = rresp;
    assign S_AXI_RDATA_O    = rdata;
    assign MODE_O           = mode_reg;
    assign TRIGGER_O        = trigger_reg;
    assign TOUCH_CFG_O      = touch_cfg;
    assign X_PLUS_SWITCH_O  = switch_cmd[0];
    assign X_MINUS_SWITCH_O = switch_cmd[1];
    assign Y_PLUS_SWITCH_O  = switch_cmd[2];
    assign Y_MINUS_SWITCH_O = switch_cmd[3];
    assign IRQ_O            = irq;

endmodule

`default_nettype wire

/* File: tcu_touch_unit_monitor.sv */
`timescale 1ns/10ps
`default_nettype none
`include "tcu_consts.svh"

module tcu_touch_unit_monitor (
    // clock and reset
    input wire logic                 SYS_CLK_I,
    input wire logic                 RST_N_I,
    // bus
    input wire logic [1:0]           S_AXI_BRESP_O,
    input wire logic                 S_AXI_BVALID_O,
    input wire logic                 S_AXI_BREADY_I,
    input wire logic [31:0]          S_AXI_ARADDR_I,
    input wire logic                 S_AXI_ARVALID_I,
    input wire logic                 S_AXI_ARREADY_O,
    input wire logic [31:0]          S_AXI_RDATA_O,
    input wire logic                 S_AXI_RVALID_O,
    input wire logic                 S_AXI_RREADY_I,
    // sequencer and panel
    input wire logic [`TCU_SW_W-1:0] SWITCH_CMD_I,
    input wire logic [31:0]          TRIGGER_O,
    input wire logic                 X_PLUS_SWITCH_O,
    input wire logic                 X_MINUS_SWITCH_O,
    input wire logic                 Y_PLUS_SWITCH_O,
    input wire logic                 Y_MINUS_SWITCH_O
);
    default clocking cb @(posedge SYS_CLK_I); endclocking
    default disable iff (!RST_N_I);
    // address of the read in flight
    logic [31:0] ar_q;
    always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I)
            ar_q <= '0;
        else if (S_AXI_ARVALID_I && S_AXI_ARREADY_O)
            ar_q <= S_AXI_ARADDR_I;
    end
    sw_follow_a: assert property ($past(RST_N_I) |->
        {Y_MINUS_SWITCH_O, Y_PLUS_SWITCH_O, X_MINUS_SWITCH_O,
        X_PLUS_SWITCH_O} == $past(SWITCH_CMD_I)) else $error("switch lag");
    res_upper_a: assert property (S_AXI_RVALID_O &&
        ar_q inside {`TCU_ADDR_XPOS, `TCU_ADDR_PRESS_ONE, `TCU_ADDR_PRESS_TWO}
        |-> S_AXI_RDATA_O[31:10] == '0) else $error("result upper bits");
    guard_bits_a: assert property (S_AXI_RVALID_O &&
        ar_q == `TCU_ADDR_GUARD_STAT |-> S_AXI_RDATA_O[7:1] == '0)
        else $error("guard status spare bits");
    cfg_write_a: assert property ($changed(TRIGGER_O)
        |-> $rose(S_AXI_BVALID_O)) else $error("trigger moved alone");
    b_hold_a: assert property (S_AXI_BVALID_O && !S_AXI_BREADY_I
        |=> S_AXI_BVALID_O && $stable(S_AXI_BRESP_O)) else $error("b drop");
    r_hold_a: assert property (S_AXI_RVALID_O && !S_AXI_RREADY_I
        |=> S_AXI_RVALID_O && $stable(S_AXI_RDATA_O)) else $error("r drop");
    rd_answer_a: assert property (S_AXI_ARVALID_I && S_AXI_ARREADY_O
        |=> S_AXI_RVALID_O && !S_AXI_ARREADY_O) else $error("read late");
    b_release_a: assert property (S_AXI_BVALID_O && S_AXI_BREADY_I
        |=> !S_AXI_BVALID_O) else $error("b stuck");
endmodule

bind tcu_touch_unit tcu_touch_unit_monitor i_tcu_touch_unit_monitor (.*);
`default_nettype wire

/* File: tcu_touch_unit_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
`include "tcu_consts.svh"

module tcu_touch_unit_tb_top;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [31:0] awaddr = '0, wdata = '0, araddr = '0;
    logic [3:0] wstrb = 4'hF, sw_cmd = '0, sw_o;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid, irq;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata, mode_o, trig_o, cfg_o;
    logic [2:0] go = '0;
    logic [9:0] lvl = '0;
    tcu_pkg::tcu_result_t [2:0] res;
    logic [31:0] exp_res [3];
    logic [31:0] ra [3] = '{`TCU_ADDR_XPOS, `TCU_ADDR_PRESS_ONE,
                            `TCU_ADDR_PRESS_TWO};
    logic [31:0] ga [3] = '{`TCU_ADDR_MODE, `TCU_ADDR_TRIGGER,
                            `TCU_ADDR_TOUCH_CFG};
    int err_total = 0, total_checks = 0;

    always #2 clk = ~clk;

    tcu_touch_unit i_tcu_touch_unit (
        .SYS_CLK_I(clk), .RST_N_I(rst_n),
        .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awvalid),
        .S_AXI_AWREADY_O(awready), .S_AXI_WDATA_I(wdata),
        .S_AXI_WSTRB_I(wstrb), .S_AXI_WVALID_I(wvalid),
        .S_AXI_WREADY_O(wready), .S_AXI_BRESP_O(bresp),
        .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready),
        .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid),
        .S_AXI_ARREADY_O(arready), .S_AXI_RDATA_O(rdata),
        .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid),
        .S_AXI_RREADY_I(rready), .CONV_RESULT_I(res),
        .SWITCH_CMD_I(sw_cmd), .MODE_O(mode_o), .TRIGGER_O(trig_o),
        .TOUCH_CFG_O(cfg_o), .X_PLUS_SWITCH_O(sw_o[0]),
        .X_MINUS_SWITCH_O(sw_o[1]), .Y_PLUS_SWITCH_O(sw_o[2]),
        .Y_MINUS_SWITCH_O(sw_o[3]), .IRQ_O(irq));

    tcu_panel_model i_tcu_panel_model (
        .clk_i(clk), .go_i(go), .level_i(lvl), .res_o(res));

    // ****
    // closing and bus tasks
    // ****
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, e, input string m);
        total_checks++;
        if (g !== e) begin
            err_total++;
            $display("ERROR %0t %s got %h exp %h", $time, m, g, e);
        end
    endtask

    // no wait is open ended: a dead slave ends the run
    task automatic bound(input int n);
        if (n >= 60) begin
            err_total++;
            $display("ERROR %0t bus wait ran out", $time);
            print_verdict();
        end
    endtask

    task automatic wr(input logic [31:0] a, d, output logic [1:0] r);
        int n;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid && n < 60);
        r = bresp;
        bready <= 1'b0;
        bound(n);
    endtask

    task automatic rd(input logic [31:0] a, output logic [31:0] d);
        int n;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
            if (arready) arvalid <= 1'b0;
        end while (!rvalid && n < 60);
        d = rdata;
        rready <= 1'b0;
        bound(n);
    endtask

    task automatic pulse(input int ch);
        @(posedge clk);
        exp_res[ch] = 32'($urandom_range(1023, 0));
        lvl <= exp_res[ch][9:0];
        go <= 3'(1 << ch);
        @(posedge clk);
        go <= '0;
        repeat (3) @(posedge clk);
    endtask

    // ****
    // main sequence
    // ****
    initial begin
        logic [31:0] d, v;
        logic [1:0] r;
        void'($urandom(32'h8bcb_8714));
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        wr(`TCU_ADDR_TOUCH_CFG, 32'h0000_0001, r);
        wr(`TCU_ADDR_IRQ_EN, 32'h0000_0008, r);
        for (int i = 0; i < 3; i++) begin
            pulse(i);
            rd(ra[i], d);
            chk(d, exp_res[i], "result");
        end
        pulse(0);
        pulse(0);
        chk({31'h0, irq}, 32'h1, "irq");
        rd(`TCU_ADDR_IRQ_STAT, d);
        chk(d, 32'h0000_000F, "flags");
        rd(`TCU_ADDR_XPOS, d);
        chk(d, exp_res[0], "x result");
        wr(`TCU_ADDR_IRQ_CLR, 32'h0000_007F, r);
        wr(`TCU_ADDR_TOUCH_CFG, 32'h0000_0000, r);
        pulse(0);
        rd(`TCU_ADDR_IRQ_STAT, d);
        chk(d, 32'h0000_0000, "done off");
        $display("test results done");
        for (int i = 0; i < 4; i++) begin
            v = 32'($urandom_range(15, 0)) | (32'h1 << i);
            @(posedge clk);
            sw_cmd <= v[3:0];
            repeat (2) @(posedge clk);
            chk({28'h0, sw_o}, v, "switch pins");
            rd(`TCU_ADDR_SWITCH, d);
            chk(d, v, "switch reg");
        end
        $display("test switches done");
        v = $urandom;
        wr(`TCU_ADDR_MODE, v, r);
        wr(`TCU_ADDR_GUARD_MODE, 32'h1234_5601, r);
        rd(`TCU_ADDR_GUARD_STAT, d);
        chk(d, 32'h0000_0000, "bad key");
        wr(`TCU_ADDR_GUARD_MODE, {`TCU_GUARD_KEY, 8'h01}, r);
        rd(`TCU_ADDR_GUARD_STAT, d);
        chk(d, 32'h0000_0001, "guard on");
        for (int i = 0; i < 3; i++) begin
            wr(ga[i], $urandom | 32'h1, r);
            rd(`TCU_ADDR_GUARD_STAT, d);
            chk(d, {8'h00, ga[i][15:0], 8'h01}, "offset");
            chk(mode_o, v, "mode kept");
            chk(trig_o | cfg_o, 32'h0, "cfg kept");
        end
        wr(`TCU_ADDR_GUARD_MODE, {`TCU_GUARD_KEY, 8'h00}, r);
        rd(`TCU_ADDR_GUARD_STAT, d);
        chk(d, 32'h0000_0C00, "guard off");
        v = $urandom;
        wr(`TCU_ADDR_TRIGGER, v, r);
        chk(trig_o, v, "trigger");
        rd(`TCU_ADDR_IRQ_STAT, d);
        chk(d, 32'h0000_0040, "violation");
        wr(`TCU_ADDR_IRQ_EN, 32'h0000_0040, r);
        repeat (2) @(posedge clk);
        chk({31'h0, irq}, 32'h1, "irq on");
        wr(`TCU_ADDR_IRQ_EN, 32'h0000_0000, r);
        repeat (2) @(posedge clk);
        chk({31'h0, irq}, 32'h0, "irq masked");
        wr(32'hFFFB_0100, $urandom, r);
        chk({30'h0, r}, {30'h0, `TCU_RESP_SLVERR}, "unmapped write");
        rd(32'hFFFB_0100, d);
        chk(d, 32'h0, "unmapped read");
        chk({30'h0, rresp}, {30'h0, `TCU_RESP_SLVERR}, "unmapped rresp");
        $display("test guard done");
        print_verdict();
    end
endmodule
`default_nettype wire
